// ==== dv/mia_aggregator_sva.sv ====
/* Port checker of the interrupt aggregator.
   Assumes one slave, so hready is fed back from hreadyout. */
`timescale 1ns/1ns
module mia_aggregator_sva
  import mia_pkg::*;
(
  // Watched ports
  input wire logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, irq_out_n, irq_oe,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hrdata,
  input wire mia_events_s events
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic xfer = hsel && hready && htrans == MIA_HTRANS_NONSEQ;
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  a_pin_drive: assert property (irq_oe == !irq_out_n)
    else $error("pin enable wrong");
  a_reset_idle: assert property ($rose(arst_n) |-> irq_out_n && hrdata == 0)
    else $error("busy after reset");
  a_set_cause: assert property ($fell(irq_out_n) |-> $past(xfer, 2) || $past(xfer, 3) ||
    $past(events.x_evt != 0 || events.y_evt != 0 || events.next_node_ready ||
    events.stack_count == MIA_STACK_ONE)) else $error("irq without event");
  a_clear_cause: assert property ($rose(irq_out_n) |-> $past(xfer) || $past(xfer, 2) ||
    $past(xfer, 3) || $past(events.interp_driving, 2) || $past(events.next_interp_cmd ||
    events.pattern_command)) else $error("release without cause");
  a_irq_hold: assert property (!$past(xfer) && !$past(xfer, 2) && !$past(xfer, 3) &&
    $past(events) == '0 && $past(events, 2) == '0 |-> $stable(irq_out_n))
    else $error("irq moved alone");
  a_read_data: assert property (hrdata != 0 |-> $past(xfer && !hwrite))
    else $error("data outside read");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper data set");
  cover property ($fell(irq_out_n));
  cover property ($rose(irq_out_n));
  cover property (xfer && !hwrite ##1 hrdata != 0);
endmodule
bind mia_aggregator mia_aggregator_sva i_sva (.clk(clk), .arst_n(arst_n), .hsel(hsel),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .irq_out_n(irq_out_n), .irq_oe(irq_oe), .htrans(htrans), .hrdata(hrdata), .events(events));

// ==== dv/mia_aggregator_tb.sv ====
/* Self-checking bench of the interrupt aggregator.
   Assumes an AHB-Lite slave; transfers wait on hreadyout, event and pin checks wait fixed clock edges. */
`timescale 1ns/1ns
module mia_aggregator_tb
  import mia_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq_out_n, irq_oe;
  logic [31:0] hrdata;
  mia_events_s ev, e, p;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  mia_event_src i_src (.clk(clk), .ev(ev));
  mia_aggregator i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .events(ev),
    .irq_out_n(irq_out_n), .irq_oe(irq_oe));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= MIA_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    if (!wr) check("register", hrdata, exp);
  endtask
  // Pin level and its enable are checked together
  task automatic pin(input logic lvl);
    @(posedge clk);
    #1 check("irq pin", {irq_out_n, irq_oe}, {lvl, !lvl});
  endtask
  task automatic pulse;
    i_src.step(e | p);
    i_src.step(e);
  endtask
  task automatic fall21;
    e.stack_count = MIA_STACK_TWO;
    i_src.step(e);
    e.stack_count = MIA_STACK_ONE;
    i_src.step(e);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    e = '0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    pin(1'b1);
    xfer(1'b0, MIA_OFS_X_ENABLE, 0, 0);
    xfer(1'b0, MIA_OFS_Y_ENABLE, 0, 0);
    xfer(1'b0, MIA_OFS_IRQ_LEVEL, 0, 0);
    xfer(1'b0, MIA_OFS_INTERP_CONFIG, 0, 0);
    xfer(1'b0, 8'h40, 0, MIA_RDATA_UNMAPPED);
    xfer(1'b1, MIA_OFS_X_ENABLE, 32'hFFFF_FFFF, 0);
    xfer(1'b0, MIA_OFS_X_ENABLE, 0, {16'h0, MIA_AXIS_EN_MASK});
    e.x_driving = 1'b1;
    for (int i = 0; i < MIA_AXIS_EVENTS; i++) begin
      p = '0;
      p.x_evt[i] = 1'b1;
      pulse();
      pin(1'b0);
      xfer(1'b0, MIA_OFS_X_STATUS, 0, 32'h1 << (i + 1));
      pin(1'b1);
    end
    // Drive end masked, then a Y event dropped while that axis is idle
    xfer(1'b1, MIA_OFS_X_ENABLE, 32'h7E00, 0);
    pulse();
    pin(1'b1);
    xfer(1'b0, MIA_OFS_X_STATUS, 0, 0);
    xfer(1'b1, MIA_OFS_Y_ENABLE, 32'hFE00, 0);
    p = '0;
    p.y_evt[6] = 1'b1;
    pulse();
    xfer(1'b0, MIA_OFS_Y_STATUS, 0, 0);
    e.y_driving = 1'b1;
    pulse();
    pin(1'b0);
    xfer(1'b0, MIA_OFS_Y_STATUS, 0, 32'h80);
    pin(1'b1);
    xfer(1'b1, MIA_OFS_INTERP_CONFIG, 32'hC000, 0);
    e.interp_driving = 1'b1;
    p = '0;
    p.next_node_ready = 1'b1;
    pulse();
    xfer(1'b0, MIA_OFS_MAIN_STATUS, 0, 32'h1);
    pin(1'b0);
    xfer(1'b0, MIA_OFS_IRQ_LEVEL, 0, 32'h1);
    // Any other command code must leave the pending interrupt alone
    xfer(1'b1, MIA_OFS_COMMAND, 32'h3E, 0);
    pin(1'b0);
    xfer(1'b1, MIA_OFS_COMMAND, {24'h0, MIA_CMD_IRQ_CLEAR}, 0);
    pin(1'b1);
    pulse();
    p = '0;
    p.next_interp_cmd = 1'b1;
    pulse();
    pin(1'b1);
    fall21();
    xfer(1'b0, MIA_OFS_MAIN_STATUS, 0, 32'h2002);
    p = '0;
    p.pattern_command = 1'b1;
    pulse();
    pin(1'b1);
    fall21();
    pin(1'b0);
    e.interp_driving = 1'b0;
    i_src.step(e);
    pin(1'b1);
    tally_and_finish;
  end
endmodule

// ==== dv/mia_event_src.sv ====
/* Model of the motion logic feeding the aggregator.
   Assumes the bench composes each whole event word. */
`timescale 1ns/1ns
module mia_event_src
  import mia_pkg::*;
(
  // Clock
  input wire logic clk,
  // Event word
  output mia_events_s ev
);
  initial ev = '0;
  // Changed just after the edge so the slave samples a whole word
  task automatic step(input mia_events_s v);
    @(posedge clk);
    ev <= v;
  endtask
endmodule

// ==== hw/mia_aggregator.sv ====
/*
  Motion interrupt aggregator: gathers axis and interpolation events into one
  active-low open-drain interrupt output, with registers on AHB-Lite.
  Assumes event inputs are one-cycle pulses synchronous to clk, and that the
  pad or testbench resolves the open-drain level from irq_out_n and irq_oe.
*/
// Overview of operation
// - Accept X, Y, bit-pattern and continuous-interpolation interrupt sources.
// - One interrupt output: OR of enabled pending sources, low when asserted, else released.
// - Every source has its own enable; reset clears all enables.
// - Enable D9, status D1: position reaches or exceeds lower compare.
// - Enable D10, status D2: position falls below lower compare.
// - Enable D11, status D3: position rises above upper compare.
// - Enable D12, status D4: position at or below upper compare.
// - Enable D13, status D5: drive enters deceleration from constant speed.
// - Enable D14, status D6: drive enters constant speed from acceleration.
// - Enable D15, status D7: drive has ended.
// - Writing 1 enables an axis event, writing 0 masks it.
// - Enabled axis event during driving sets its status bit and pulls output low.
// - Reading axis status clears its set bits and releases the output.
// - Config D14 enables next-node interrupt, shown in main status D9; next command clears.
// - Config D15 enables stack 2-to-1 interrupt, stack in D14..13; pattern command clears.
// - Command 3Dh clears pending interpolation interrupts and releases the output.
// - End of interpolation drive releases the interpolation interrupt automatically.
`timescale 1ns/1ns
module mia_aggregator
  import mia_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event sources
  input wire mia_events_s events,
  // Open-drain interrupt pin
  output logic irq_out_n,
  output logic irq_oe
);

  mia_state_s state_reg;
  mia_state_s state_next;

  // Latch enabled axis events; set wins over a read-clear in the same cycle
  function automatic logic [15:0] axis_update(
    input logic [15:0] st,
    input logic [15:0] en,
    input logic [MIA_AXIS_EVENTS-1:0] evt,
    input logic driving,
    input logic clear
  );
    logic [15:0] set_bits;
    logic [15:0] res;
    set_bits = '0;
    for (int i = 0; i < MIA_AXIS_EVENTS; i++) begin
      set_bits[MIA_AXIS_ST_LSB + i] = evt[i] & en[MIA_AXIS_EN_LSB + i] & driving;
    end
    res = clear ? 16'h0000 : st;
    return res | set_bits;
  endfunction

  // Axis flags pend only while their enable is still set
  function automatic logic axis_pending(input logic [15:0] st, input logic [15:0] en);
    logic p;
    p = 1'b0;
    for (int i = 0; i < MIA_AXIS_EVENTS; i++) begin
      p = p | (st[MIA_AXIS_ST_LSB + i] & en[MIA_AXIS_EN_LSB + i]);
    end
    return p;
  endfunction

  logic dp_rd;
  logic dp_wr;
  logic rd_x_st;
  logic rd_y_st;
  logic cmd_clear;
  logic cont_set;
  logic pat_set;
  logic drive_end;
  logic any_pend;
  logic [31:0] rdata;
  logic [15:0] main_st;

  always_comb begin
    state_next = state_reg;
    dp_rd = state_reg.ap.sel & ~state_reg.ap.write;
    dp_wr = state_reg.ap.sel & state_reg.ap.write;
    rd_x_st = dp_rd & (state_reg.ap.addr == MIA_OFS_X_STATUS);
    rd_y_st = dp_rd & (state_reg.ap.addr == MIA_OFS_Y_STATUS);
    cmd_clear = dp_wr & (state_reg.ap.addr == MIA_OFS_COMMAND)
      & (hwdata[7:0] == MIA_CMD_IRQ_CLEAR);

    // Address phase capture; every transfer completes in one data cycle
    state_next.ap.sel = hsel & hready & (htrans == MIA_HTRANS_NONSEQ);
    state_next.ap.write = hwrite;
    state_next.ap.addr = haddr[7:0];

    if (dp_wr) begin
      case (state_reg.ap.addr)
        MIA_OFS_X_ENABLE: state_next.x_en = hwdata[15:0] & MIA_AXIS_EN_MASK;
        MIA_OFS_Y_ENABLE: state_next.y_en = hwdata[15:0] & MIA_AXIS_EN_MASK;
        MIA_OFS_INTERP_CONFIG: state_next.interp_cfg = hwdata[15:0];
        default: ;
      endcase
    end

    state_next.x_st = axis_update(state_reg.x_st, state_reg.x_en, events.x_evt,
      events.x_driving, rd_x_st);
    state_next.y_st = axis_update(state_reg.y_st, state_reg.y_en, events.y_evt,
      events.y_driving, rd_y_st);

    // Interpolation sources
    cont_set = events.next_node_ready & state_reg.interp_cfg[MIA_CONT_IRQ_EN_BIT];
    pat_set = (state_reg.stack_prev == MIA_STACK_TWO) & (events.stack_count == MIA_STACK_ONE)
      & state_reg.interp_cfg[MIA_PAT_IRQ_EN_BIT];
    drive_end = state_reg.interp_drv_prev & ~events.interp_driving;
    state_next.stack_prev = events.stack_count;
    state_next.interp_drv_prev = events.interp_driving;
    if (events.next_interp_cmd | cmd_clear | drive_end) begin
      state_next.cont_pend = 1'b0;
    end
    if (events.pattern_command | cmd_clear | drive_end) begin
      state_next.pat_pend = 1'b0;
    end
    // A new event outranks any clear in the same cycle
    if (cont_set) begin
      state_next.cont_pend = 1'b1;
    end
    if (pat_set) begin
      state_next.pat_pend = 1'b1;
    end

    any_pend = axis_pending(state_next.x_st, state_next.x_en)
      | axis_pending(state_next.y_st, state_next.y_en)
      | (state_next.cont_pend & state_next.interp_cfg[MIA_CONT_IRQ_EN_BIT])
      | (state_next.pat_pend & state_next.interp_cfg[MIA_PAT_IRQ_EN_BIT]);
    state_next.irq_n = ~any_pend;
    state_next.irq_oe = any_pend;
    // Zero wait states and always OKAY, yet still registered for clean outputs
    state_next.bus_ready = 1'b1;
    state_next.bus_err = 1'b0;

    main_st = '0;
    main_st[MIA_NEXT_NODE_BIT] = events.next_node_ready;
    main_st[MIA_PAT_STACK_LSB +: 2] = events.stack_count;
    main_st[MIA_CONT_PEND_BIT] = state_reg.cont_pend;
    main_st[MIA_PAT_PEND_BIT] = state_reg.pat_pend;

    // Read data for the address now in its address phase
    rdata = MIA_RDATA_UNMAPPED;
    case (haddr[7:0])
      MIA_OFS_X_ENABLE: rdata = {16'h0000, state_next.x_en};
      MIA_OFS_Y_ENABLE: rdata = {16'h0000, state_next.y_en};
      MIA_OFS_X_STATUS: rdata = {16'h0000, state_next.x_st};
      MIA_OFS_Y_STATUS: rdata = {16'h0000, state_next.y_st};
      MIA_OFS_INTERP_CONFIG: rdata = {16'h0000, state_next.interp_cfg};
      MIA_OFS_MAIN_STATUS: rdata = {16'h0000, main_st};
      MIA_OFS_IRQ_LEVEL: rdata = {31'h0000_0000, any_pend};
      default: rdata = MIA_RDATA_UNMAPPED;
    endcase
    state_next.hrdata = state_next.ap.sel & ~hwrite ? rdata : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '0;
      state_reg.x_en <= MIA_ENABLE_RESET;
      state_reg.y_en <= MIA_ENABLE_RESET;
      state_reg.interp_cfg <= MIA_CONFIG_RESET;
      state_reg.irq_n <= 1'b1;
      state_reg.bus_ready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hreadyout = state_reg.bus_ready;
  assign hresp = state_reg.bus_err;
  assign hrdata = state_reg.hrdata;
  assign irq_out_n = state_reg.irq_n;
  assign irq_oe = state_reg.irq_oe;

endmodule

// ==== inc/mia_pkg.sv ====
/*
  Package of the motion interrupt aggregator: register map, field positions,
  reset values, command codes and the carrier structs.
  Assumes a 32-bit AHB-Lite register bus and a single system clock.
*/
package mia_pkg;
  // Register byte offsets
  localparam logic [7:0] MIA_OFS_X_ENABLE = 8'h00;
  localparam logic [7:0] MIA_OFS_Y_ENABLE = 8'h04;
  localparam logic [7:0] MIA_OFS_X_STATUS = 8'h08;
  localparam logic [7:0] MIA_OFS_Y_STATUS = 8'h0C;
  localparam logic [7:0] MIA_OFS_INTERP_CONFIG = 8'h10;
  localparam logic [7:0] MIA_OFS_MAIN_STATUS = 8'h14;
  localparam logic [7:0] MIA_OFS_COMMAND = 8'h18;
  localparam logic [7:0] MIA_OFS_IRQ_LEVEL = 8'h1C;

  // Axis enable bits D9..D15 map to status bits D1..D7
  localparam int MIA_AXIS_EN_LSB = 9;
  localparam int MIA_AXIS_ST_LSB = 1;
  localparam int MIA_AXIS_EVENTS = 7;
  localparam logic [15:0] MIA_AXIS_EN_MASK = 16'hFE00;
  // Interpolation config enables
  localparam int MIA_CONT_IRQ_EN_BIT = 14;
  localparam int MIA_PAT_IRQ_EN_BIT = 15;
  // Main status fields
  localparam int MIA_NEXT_NODE_BIT = 9;
  localparam int MIA_PAT_STACK_LSB = 13;
  localparam int MIA_CONT_PEND_BIT = 0;
  localparam int MIA_PAT_PEND_BIT = 1;

  localparam logic [15:0] MIA_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] MIA_CONFIG_RESET = 16'h0000;

  // Command code and stack-count values
  localparam logic [7:0] MIA_CMD_IRQ_CLEAR = 8'h3D;
  localparam logic [1:0] MIA_STACK_ONE = 2'h1;
  localparam logic [1:0] MIA_STACK_TWO = 2'h2;

  localparam logic [1:0] MIA_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] MIA_RDATA_UNMAPPED = 32'h0000_0000;

  // Per-axis event pulses, bit i = axis status bit i+1
  typedef struct packed {
    logic [MIA_AXIS_EVENTS-1:0] x_evt;
    logic [MIA_AXIS_EVENTS-1:0] y_evt;
    logic x_driving;
    logic y_driving;
    logic next_node_ready;
    logic [1:0] stack_count;
    logic interp_driving;
    logic next_interp_cmd;
    logic pattern_command;
  } mia_events_s;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } mia_aphase_s;

  typedef struct packed {
    mia_aphase_s ap;
    logic [15:0] x_en;
    logic [15:0] y_en;
    logic [15:0] x_st;
    logic [15:0] y_st;
    logic [15:0] interp_cfg;
    logic cont_pend;
    logic pat_pend;
    logic [1:0] stack_prev;
    logic interp_drv_prev;
    logic irq_n;
    logic irq_oe;
    logic bus_ready;
    logic bus_err;
    logic [31:0] hrdata;
  } mia_state_s;
endpackage
